// ==== logic/alfrc_pkg.sv ====
// Constants shared by the alarm and fan relay controller
package alfrc_pkg;
  // Register byte offsets on each processor bus
  localparam logic [5:0] ADDR_ALARM_REQ  = 6'h00;
  localparam logic [5:0] ADDR_CENTRE     = 6'h04;
  localparam logic [5:0] ADDR_FAN_SET    = 6'h08;
  localparam logic [5:0] ADDR_FAN_CLR    = 6'h0c;
  localparam logic [5:0] ADDR_FAN_STATE  = 6'h10;
  localparam logic [5:0] ADDR_FAN_ALARM  = 6'h14;
  localparam logic [5:0] ADDR_LED        = 6'h18;
  localparam logic [5:0] ADDR_RELAY      = 6'h1c;
  localparam logic [5:0] ADDR_LAMP       = 6'h20;
  localparam logic [5:0] ADDR_INT_STAT   = 6'h24;
  localparam logic [5:0] ADDR_INT_CLR    = 6'h28;
  localparam logic [5:0] ADDR_INT_EN     = 6'h2c;
  localparam logic [5:0] ADDR_GP_RELAY   = 6'h30;
  localparam logic [5:0] ADDR_SYS        = 6'h34;
  // Field positions
  localparam int CRIT_LSB     = 0;
  localparam int MAJ_LSB      = 8;
  localparam int MIN_LSB      = 16;
  localparam int AUD_BIT      = 24;
  localparam int REMOTE_LSB   = 0;
  localparam int LOCAL_LSB    = 8;
  localparam int LAMP_LSB     = 0;
  localparam int LAMP_OUT_LSB = 8;
  localparam int LAMP_LOC_LSB = 16;
  localparam int LED_CRIT_LSB = 0;
  localparam int LED_MAJ_LSB  = 2;
  localparam int LED_MIN_LSB  = 4;
  localparam int INT_LAMP_LSB = 0;
  localparam int INT_INSANE   = 3;
  localparam int INT_FAN_LSB  = 8;
  localparam int SYS_SANE_A   = 0;
  localparam int SYS_SANE_B   = 1;
  localparam int SYS_MASTER_B = 2;
  localparam int SYS_PASS     = 3;
  // Reset values
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  localparam logic [5:0]  LED_RST = 6'h00;
  // Bicolour indicator codes
  typedef enum logic [1:0] {
    LED_OFF   = 2'b00,
    LED_RED   = 2'b01,
    LED_GREEN = 2'b10,
    LED_AMBER = 2'b11
  } alfrc_led_type;
endpackage

// ==== logic/alfrc_top.sv ====
// Alarm and fan relay controller shared by two processor cards
// Summary of operation
// RULE1 - Major and minor relays need a master request and at least one sane processor.
// RULE2 - Critical relay follows the request, or is forced when both processors are insane.
// RULE3 - Remote centre alarms pass only while the master's transfer signal is active.
// RULE4 - Remote alarm active with no sensed lamp current flags a lamp fault.
// RULE5 - Relay state is readable on both processor buses whoever is master.
// RULE6 - Critical, major, minor relays for up to six racks plus one audible alarm.
// RULE7 - One fan relay per frame, each set or cleared without touching others.
// RULE8 - Fan output is driven active to stop fans; undriven means fans run.
// RULE9 - One fan alarm input per frame, each readable individually.
// RULE10 - Three software LEDs; alarm LEDs hold four software states, apart from relays.
// RULE11 - Each processor LED is green while that processor is master, else off.
// RULE12 - Buzzer sounds when both insane, or sane and master requests audible alarm.
// RULE13 - Software shows alarms red or amber on LEDs, green when clear.
// RULE14 - General purpose relays have no reset; only processor writes change them.
// RULE15 - Alarm updates and status readback travel over the processor link.
// RULE16 - Sanity, transfer and sense inputs pass two flip-flops before use.
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
module alfrc_top #(
  parameter int RACKS     = 6,
  parameter int CENTRES   = 3,
  parameter int FRAMES    = 6,
  parameter int GP_RELAYS = 8
) (
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 ce_i,
  input  wire logic [5:0]           bus_a_addr_i,
  input  wire logic [31:0]          bus_a_wdata_i,
  input  wire logic                 bus_a_wr_i,
  input  wire logic                 bus_a_rd_i,
  output logic      [31:0]          bus_a_rdata_o,
  input  wire logic [5:0]           bus_b_addr_i,
  input  wire logic [31:0]          bus_b_wdata_i,
  input  wire logic                 bus_b_wr_i,
  input  wire logic                 bus_b_rd_i,
  output logic      [31:0]          bus_b_rdata_o,
  input  wire logic                 sane_a_i,
  input  wire logic                 sane_b_i,
  input  wire logic                 master_b_i,
  input  wire logic                 xfer_a_i,
  input  wire logic                 xfer_b_i,
  input  wire logic [CENTRES-1:0]   lamp_sense_i,
  input  wire logic [FRAMES-1:0]    fan_alarm_i,
  output logic      [RACKS-1:0]     crit_relay_o,
  output logic      [RACKS-1:0]     major_relay_o,
  output logic      [RACKS-1:0]     minor_relay_o,
  output logic                      buzzer_o,
  output logic      [CENTRES-1:0]   remote_centre_alarm_o,
  output logic      [CENTRES-1:0]   local_centre_alarm_o,
  output logic      [FRAMES-1:0]    fan_off_o,
  output logic      [GP_RELAYS-1:0] gp_relay_o,
  output logic      [1:0]           led_critical_o,
  output logic      [1:0]           led_major_o,
  output logic      [1:0]           led_minor_o,
  output logic                      processor_a_master_led_o,
  output logic                      processor_b_master_led_o,
  output logic                      irq_o
);
  localparam int SW = 5 + CENTRES + FRAMES;
  localparam int IW = alfrc_pkg::INT_FAN_LSB + FRAMES;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [SW-1:0] sync1_r, sync2_r, sync1_nxt, sync2_nxt;
  logic          sane_a, sane_b, mst_b, pass_en, any_sane, both_insane;
  logic [CENTRES-1:0] sense;
  logic [FRAMES-1:0]  fan_al;

  always_comb
  begin
    sync1_nxt = {fan_alarm_i, lamp_sense_i, xfer_b_i, xfer_a_i, master_b_i, sane_b_i, sane_a_i}; // RULE16
    sync2_nxt = sync1_r; // RULE16
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else if (ce_i)
    begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
    end
  end

  // Reset shows both processors insane, so critical relays start alarming
  assign sane_a      = sync2_r[0];
  assign sane_b      = sync2_r[1];
  assign mst_b       = sync2_r[2];
  assign sense       = sync2_r[5 +: CENTRES];
  assign fan_al      = sync2_r[5+CENTRES +: FRAMES];
  assign pass_en     = mst_b ? sync2_r[4] : sync2_r[3]; // RULE3
  assign any_sane    = sane_a | sane_b;
  assign both_insane = ~any_sane;

  ////////////////////////////////////////////////////////////////////////////
  // Software registers; only the master's bus may write
  logic        w_en;
  logic [5:0]  w_addr;
  logic [31:0] w_data;
  logic [RACKS-1:0]   crit_req_r, maj_req_r, min_req_r, crit_req_nxt, maj_req_nxt, min_req_nxt;
  logic               aud_req_r, aud_req_nxt;
  logic [CENTRES-1:0] rem_req_r, loc_req_r, rem_req_nxt, loc_req_nxt;
  logic [FRAMES-1:0]  fan_r, fan_nxt;
  logic [5:0]         led_r, led_nxt;
  logic [IW-1:0]      int_en_r, int_en_nxt, int_stat_r, int_stat_nxt, int_ev, int_clr;
  logic [GP_RELAYS-1:0] gp_r, gp_nxt;

  // Standby's writes are dropped so it cannot fight the master
  assign w_en   = mst_b ? bus_b_wr_i : bus_a_wr_i; // RULE15
  assign w_addr = mst_b ? bus_b_addr_i : bus_a_addr_i;
  assign w_data = mst_b ? bus_b_wdata_i : bus_a_wdata_i;
  assign int_clr = (w_en && w_addr == alfrc_pkg::ADDR_INT_CLR) ? w_data[IW-1:0] : '0;

  always_comb
  begin
    crit_req_nxt = crit_req_r;
    maj_req_nxt  = maj_req_r;
    min_req_nxt  = min_req_r;
    aud_req_nxt  = aud_req_r;
    rem_req_nxt  = rem_req_r;
    loc_req_nxt  = loc_req_r;
    fan_nxt      = fan_r;
    led_nxt      = led_r;
    int_en_nxt   = int_en_r;
    gp_nxt       = gp_r;
    if (w_en)
    begin
      unique case (w_addr)
        alfrc_pkg::ADDR_ALARM_REQ:
        begin
          crit_req_nxt = w_data[alfrc_pkg::CRIT_LSB +: RACKS];
          maj_req_nxt  = w_data[alfrc_pkg::MAJ_LSB +: RACKS];
          min_req_nxt  = w_data[alfrc_pkg::MIN_LSB +: RACKS];
          aud_req_nxt  = w_data[alfrc_pkg::AUD_BIT];
        end
        alfrc_pkg::ADDR_CENTRE:
        begin
          rem_req_nxt = w_data[alfrc_pkg::REMOTE_LSB +: CENTRES];
          loc_req_nxt = w_data[alfrc_pkg::LOCAL_LSB +: CENTRES];
        end
        alfrc_pkg::ADDR_FAN_SET:  fan_nxt = fan_r | w_data[FRAMES-1:0]; // RULE7
        alfrc_pkg::ADDR_FAN_CLR:  fan_nxt = fan_r & ~w_data[FRAMES-1:0]; // RULE7
        alfrc_pkg::ADDR_LED:      led_nxt = w_data[5:0]; // RULE10
        alfrc_pkg::ADDR_INT_EN:   int_en_nxt = w_data[IW-1:0];
        alfrc_pkg::ADDR_GP_RELAY: gp_nxt = w_data[GP_RELAYS-1:0]; // RULE14
        default: ;
      endcase
    end
    // A new event outweighs a clear in the same cycle
    int_stat_nxt = (int_stat_r & ~int_clr) | int_ev;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      crit_req_r <= '0;
      maj_req_r  <= '0;
      min_req_r  <= '0;
      aud_req_r  <= 1'b0;
      rem_req_r  <= '0;
      loc_req_r  <= '0;
      fan_r      <= '0;
      led_r      <= alfrc_pkg::LED_RST;
      int_en_r   <= '0;
      int_stat_r <= '0;
    end
    else if (ce_i)
    begin
      crit_req_r <= crit_req_nxt;
      maj_req_r  <= maj_req_nxt;
      min_req_r  <= min_req_nxt;
      aud_req_r  <= aud_req_nxt;
      rem_req_r  <= rem_req_nxt;
      loc_req_r  <= loc_req_nxt;
      fan_r      <= fan_nxt;
      led_r      <= led_nxt;
      int_en_r   <= int_en_nxt;
      int_stat_r <= int_stat_nxt;
    end
  end

  // General purpose relays keep their contacts across a controller reset
  always_ff @(posedge sys_clk_i)
  begin
    if (ce_i)
    begin
      gp_r <= gp_nxt; // RULE14
    end
  end

  assign gp_relay_o = gp_r; // RULE14

  ////////////////////////////////////////////////////////////////////////////
  // Relay, LED and event logic
  logic [RACKS-1:0]   crit_nxt, maj_nxt, min_nxt;
  logic               buzz_nxt, led_a_nxt, led_b_nxt, irq_nxt, insane_d_r;
  logic [CENTRES-1:0] rem_out_nxt, lamp_r, lamp_nxt;
  logic [FRAMES-1:0]  fan_al_d_r;

  always_comb
  begin
    crit_nxt    = crit_req_r | {RACKS{both_insane}}; // RULE2 RULE6
    maj_nxt     = maj_req_r & {RACKS{any_sane}}; // RULE1 RULE6
    min_nxt     = min_req_r & {RACKS{any_sane}}; // RULE1 RULE6
    buzz_nxt    = both_insane | (any_sane & aud_req_r); // RULE12 RULE6
    rem_out_nxt = rem_req_r & {CENTRES{pass_en}}; // RULE3
    // Compares the driven relay to its sense, so a fault lags the relay by one cycle
    lamp_nxt    = remote_centre_alarm_o & ~sense; // RULE4
    led_a_nxt   = ~mst_b; // RULE11
    led_b_nxt   = mst_b; // RULE11
    int_ev      = '0;
    int_ev[alfrc_pkg::INT_LAMP_LSB +: CENTRES] = lamp_nxt & ~lamp_r;
    int_ev[alfrc_pkg::INT_INSANE]              = both_insane & ~insane_d_r;
    int_ev[alfrc_pkg::INT_FAN_LSB +: FRAMES]   = fan_al & ~fan_al_d_r;
    irq_nxt     = |(int_stat_nxt & int_en_r);
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      crit_relay_o             <= '1;
      major_relay_o            <= '0;
      minor_relay_o            <= '0;
      buzzer_o                 <= 1'b0;
      remote_centre_alarm_o    <= '0;
      local_centre_alarm_o     <= '0;
      fan_off_o                <= '0;
      led_critical_o           <= alfrc_pkg::LED_OFF;
      led_major_o              <= alfrc_pkg::LED_OFF;
      led_minor_o              <= alfrc_pkg::LED_OFF;
      processor_a_master_led_o <= 1'b0;
      processor_b_master_led_o <= 1'b0;
      irq_o                    <= 1'b0;
      lamp_r                   <= '0;
      insane_d_r               <= 1'b1;
      fan_al_d_r               <= '0;
    end
    else if (ce_i)
    begin
      crit_relay_o             <= crit_nxt;
      major_relay_o            <= maj_nxt;
      minor_relay_o            <= min_nxt;
      buzzer_o                 <= buzz_nxt;
      remote_centre_alarm_o    <= rem_out_nxt;
      local_centre_alarm_o     <= loc_req_r;
      fan_off_o                <= fan_r; // RULE8
      led_critical_o           <= led_r[alfrc_pkg::LED_CRIT_LSB +: 2]; // RULE10
      led_major_o              <= led_r[alfrc_pkg::LED_MAJ_LSB +: 2];
      led_minor_o              <= led_r[alfrc_pkg::LED_MIN_LSB +: 2];
      processor_a_master_led_o <= led_a_nxt;
      processor_b_master_led_o <= led_b_nxt;
      irq_o                    <= irq_nxt;
      lamp_r                   <= lamp_nxt;
      insane_d_r               <= both_insane;
      fan_al_d_r               <= fan_al;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read ports, one per processor bus
  logic [31:0] rdata_a_nxt, rdata_b_nxt;

  function automatic logic [31:0] read_word(input logic [5:0] addr);
    logic [31:0] v;
    v = alfrc_pkg::REG_RST;
    unique case (addr)
      alfrc_pkg::ADDR_ALARM_REQ:
      begin
        v[alfrc_pkg::CRIT_LSB +: RACKS] = crit_req_r;
        v[alfrc_pkg::MAJ_LSB +: RACKS]  = maj_req_r;
        v[alfrc_pkg::MIN_LSB +: RACKS]  = min_req_r;
        v[alfrc_pkg::AUD_BIT]           = aud_req_r;
      end
      alfrc_pkg::ADDR_CENTRE:
      begin
        v[alfrc_pkg::REMOTE_LSB +: CENTRES] = rem_req_r;
        v[alfrc_pkg::LOCAL_LSB +: CENTRES]  = loc_req_r;
      end
      alfrc_pkg::ADDR_FAN_STATE: v[FRAMES-1:0] = fan_off_o;
      alfrc_pkg::ADDR_FAN_ALARM: v[FRAMES-1:0] = fan_al; // RULE9
      alfrc_pkg::ADDR_LED:       v[5:0] = led_r;
      alfrc_pkg::ADDR_RELAY:
      begin
        v[alfrc_pkg::CRIT_LSB +: RACKS] = crit_relay_o; // RULE5
        v[alfrc_pkg::MAJ_LSB +: RACKS]  = major_relay_o;
        v[alfrc_pkg::MIN_LSB +: RACKS]  = minor_relay_o;
        v[alfrc_pkg::AUD_BIT]           = buzzer_o;
      end
      alfrc_pkg::ADDR_LAMP:
      begin
        v[alfrc_pkg::LAMP_LSB +: CENTRES]     = lamp_r;
        v[alfrc_pkg::LAMP_OUT_LSB +: CENTRES] = remote_centre_alarm_o;
        v[alfrc_pkg::LAMP_LOC_LSB +: CENTRES] = local_centre_alarm_o;
      end
      alfrc_pkg::ADDR_INT_STAT:  v[IW-1:0] = int_stat_r;
      alfrc_pkg::ADDR_INT_EN:    v[IW-1:0] = int_en_r;
      alfrc_pkg::ADDR_GP_RELAY:  v[GP_RELAYS-1:0] = gp_r;
      alfrc_pkg::ADDR_SYS:
      begin
        v[alfrc_pkg::SYS_SANE_A]   = sane_a;
        v[alfrc_pkg::SYS_SANE_B]   = sane_b;
        v[alfrc_pkg::SYS_MASTER_B] = mst_b;
        v[alfrc_pkg::SYS_PASS]     = pass_en;
      end
      default: ;
    endcase
    return v;
  endfunction

  always_comb
  begin
    rdata_a_nxt = bus_a_rd_i ? read_word(bus_a_addr_i) : alfrc_pkg::REG_RST; // RULE5
    rdata_b_nxt = bus_b_rd_i ? read_word(bus_b_addr_i) : alfrc_pkg::REG_RST; // RULE5
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      bus_a_rdata_o <= alfrc_pkg::REG_RST;
      bus_b_rdata_o <= alfrc_pkg::REG_RST;
    end
    else if (ce_i)
    begin
      bus_a_rdata_o <= rdata_a_nxt;
      bus_b_rdata_o <= rdata_b_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_MAJ_MIN_GATED: assert property (ce_i && !any_sane |=> major_relay_o == '0 && minor_relay_o == '0) // RULE1
    else $error("major or minor relay set with no sane processor");
  AST_CRIT_FORCED: assert property (ce_i && both_insane |=> crit_relay_o == '1) // RULE2
    else $error("critical relay not forced when both insane");
  AST_REMOTE_BLOCK: assert property (ce_i && !pass_en |=> remote_centre_alarm_o == '0) // RULE3
    else $error("remote alarm passed without transfer");
  AST_LAMP_FAULT: assert property (ce_i && (remote_centre_alarm_o & ~sense) != '0 |=> lamp_r != '0) // RULE4
    else $error("lamp fault not flagged");
  AST_RELAY_READ_B: assert property (ce_i && bus_b_rd_i && bus_b_addr_i == alfrc_pkg::ADDR_RELAY
                                     |=> bus_b_rdata_o[RACKS-1:0] == $past(crit_relay_o)) // RULE5
    else $error("relay state not readable on bus b");
  AST_FAN_HOLD: assert property (ce_i && !(w_en && (w_addr == alfrc_pkg::ADDR_FAN_SET
                                 || w_addr == alfrc_pkg::ADDR_FAN_CLR)) ##1 ce_i |=> fan_off_o == $past(fan_off_o)) // RULE7
    else $error("fan relay changed without a fan write");
  AST_FAN_CLR: assert property (ce_i && w_en && w_addr == alfrc_pkg::ADDR_FAN_CLR ##1 ce_i
                                |=> (fan_off_o & $past(w_data[FRAMES-1:0], 2)) == '0) // RULE8
    else $error("cleared fan still driven off");
  AST_FAN_ALARM_READ: assert property (ce_i && bus_a_rd_i && bus_a_addr_i == alfrc_pkg::ADDR_FAN_ALARM
                                       |=> bus_a_rdata_o[FRAMES-1:0] == $past(fan_al)) // RULE9
    else $error("fan alarm readback wrong");
  AST_MASTER_LED: assert property (ce_i && mst_b |=> processor_b_master_led_o && !processor_a_master_led_o) // RULE11
    else $error("master led does not follow master");
  AST_BUZZER: assert property (ce_i && any_sane && !aud_req_r |=> !buzzer_o) // RULE12
    else $error("buzzer sounded without cause");
  AST_SET_WINS: assert property (ce_i && int_ev != '0 |=> (int_stat_r & $past(int_ev)) == $past(int_ev))
    else $error("interrupt event lost");
endmodule

// ==== test/alfrc_panel_model.sv ====
// Row end panel lamps and frame fan trays seen by the alarm card
`timescale 1ns/10ps
module alfrc_panel_model (
  input  wire logic [2:0] remote_centre_alarm_i,
  input  wire logic [2:0] lamp_broken_i,
  input  wire logic [5:0] fan_fail_i,
  output logic      [2:0] lamp_sense_o,
  output logic      [5:0] fan_alarm_o
);
  ////////////////////////////////////////////////////////////////////////////
  // A burnt-out lamp draws no current even while its relay is closed
  assign lamp_sense_o = remote_centre_alarm_i & ~lamp_broken_i;
  assign fan_alarm_o  = fan_fail_i;
endmodule

// ==== test/test_alfrc_top.sv ====
// Self-checking bench for the alarm and fan relay controller
`timescale 1ns/10ps
`define CHK(nm, exp, got) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      error_cnt++; \
      $display("unexpected %s: expected %h seen %h", nm, exp, got); \
    end \
  end
module test_alfrc_top;
  logic        sys_clk_i, rst_n_i, ce, a_wr, a_rd, b_wr, b_rd;
  logic [5:0]  a_addr, b_addr, fan_alarm, fan_fail, crit, major, minor, fan_off;
  logic [31:0] a_wdata, b_wdata, a_rdata, b_rdata;
  logic        sane_a, sane_b, master_b, xfer_a, xfer_b, buzzer, led_a, led_b, irq;
  logic [2:0]  lamp_sense, remote_out, local_out, lamp_broken;
  logic [1:0]  led_c, led_j, led_n;
  logic [7:0]  gp;
  int          error_cnt, n_checks, cycles;
  ////////////////////////////////////////////////////////////////////////////
  alfrc_top alfrc_top_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce),
    .bus_a_addr_i(a_addr), .bus_a_wdata_i(a_wdata), .bus_a_wr_i(a_wr), .bus_a_rd_i(a_rd),
    .bus_a_rdata_o(a_rdata), .bus_b_addr_i(b_addr), .bus_b_wdata_i(b_wdata), .bus_b_wr_i(b_wr),
    .bus_b_rd_i(b_rd), .bus_b_rdata_o(b_rdata), .sane_a_i(sane_a), .sane_b_i(sane_b),
    .master_b_i(master_b), .xfer_a_i(xfer_a), .xfer_b_i(xfer_b), .lamp_sense_i(lamp_sense),
    .fan_alarm_i(fan_alarm), .crit_relay_o(crit), .major_relay_o(major), .minor_relay_o(minor),
    .buzzer_o(buzzer), .remote_centre_alarm_o(remote_out), .local_centre_alarm_o(local_out),
    .fan_off_o(fan_off), .gp_relay_o(gp), .led_critical_o(led_c), .led_major_o(led_j),
    .led_minor_o(led_n), .processor_a_master_led_o(led_a), .processor_b_master_led_o(led_b),
    .irq_o(irq));
  alfrc_panel_model alfrc_panel_model_i (.remote_centre_alarm_i(remote_out),
    .lamp_broken_i(lamp_broken), .fan_fail_i(fan_fail), .lamp_sense_o(lamp_sense),
    .fan_alarm_o(fan_alarm));
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  task automatic give_verdict();
    if (error_cnt == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Tests need about 150 cycles; the ceiling leaves ample margin
  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic bus_wr(input logic sel, input logic [5:0] addr, input logic [31:0] data);
    @(posedge sys_clk_i);
    if (sel)
    begin
      b_addr  <= addr;
      b_wdata <= data;
      b_wr    <= 1'b1;
    end
    else
    begin
      a_addr  <= addr;
      a_wdata <= data;
      a_wr    <= 1'b1;
    end
    @(posedge sys_clk_i);
    a_wr <= 1'b0;
    b_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample right there
  task automatic bus_rd(input logic sel, input logic [5:0] addr, input logic [31:0] exp);
    @(posedge sys_clk_i);
    if (sel)
    begin
      b_addr <= addr;
      b_rd   <= 1'b1;
    end
    else
    begin
      a_addr <= addr;
      a_rd   <= 1'b1;
    end
    @(posedge sys_clk_i);
    a_rd <= 1'b0;
    b_rd <= 1'b0;
    #1;
    `CHK("read data", exp, (sel ? b_rdata : a_rdata))
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rst_n_i, a_wr, a_rd, b_wr, b_rd, a_addr, b_addr, a_wdata, b_wdata} = '0;
    {sane_a, sane_b, master_b, xfer_a, xfer_b, fan_fail} = '0;
    ce = 1'b1;
    lamp_broken = 3'h4;
    repeat (10) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    settle(1);
    `CHK("crit at start", 6'h3f, crit)
    @(posedge sys_clk_i);
    sane_a <= 1'b1;
    sane_b <= 1'b1;
    settle(2);
    `CHK("crit before sync", 6'h3f, crit)
    settle(1);
    `CHK("crit after sync", 6'h00, crit)
    `CHK("led a", 1'b1, led_a)
    `CHK("led b", 1'b0, led_b)
    bus_wr(0, alfrc_pkg::ADDR_INT_CLR, 32'hffff_ffff);
    bus_wr(0, alfrc_pkg::ADDR_ALARM_REQ, 32'h012a_1525);
    settle(2);
    `CHK("crit", 6'h25, crit)
    `CHK("major", 6'h15, major)
    `CHK("minor", 6'h2a, minor)
    `CHK("buzzer", 1'b1, buzzer)
    bus_rd(1, alfrc_pkg::ADDR_RELAY, 32'h012a_1525);
    bus_rd(0, alfrc_pkg::ADDR_RELAY, 32'h012a_1525);
    bus_wr(1, alfrc_pkg::ADDR_ALARM_REQ, 32'h0);
    settle(2);
    `CHK("standby write", 6'h15, major)
    @(posedge sys_clk_i);
    sane_a <= 1'b0;
    sane_b <= 1'b0;
    settle(4);
    `CHK("crit insane", 6'h3f, crit)
    `CHK("major insane", 6'h00, major)
    `CHK("minor insane", 6'h00, minor)
    bus_rd(0, alfrc_pkg::ADDR_INT_STAT, 32'h8);
    bus_wr(0, alfrc_pkg::ADDR_INT_EN, 32'h8);
    settle(2);
    `CHK("irq raised", 1'b1, irq)
    bus_wr(0, alfrc_pkg::ADDR_INT_EN, 32'h0);
    settle(2);
    `CHK("irq masked", 1'b0, irq)
    bus_wr(0, alfrc_pkg::ADDR_INT_EN, 32'h8);
    bus_wr(0, alfrc_pkg::ADDR_INT_CLR, 32'h8);
    settle(2);
    `CHK("irq cleared", 1'b0, irq)
    @(posedge sys_clk_i);
    sane_b   <= 1'b1;
    master_b <= 1'b1;
    settle(4);
    `CHK("major one sane", 6'h15, major)
    `CHK("led a standby", 1'b0, led_a)
    `CHK("led b master", 1'b1, led_b)
    bus_wr(1, alfrc_pkg::ADDR_ALARM_REQ, 32'h0);
    bus_wr(0, alfrc_pkg::ADDR_ALARM_REQ, 32'h0100_0000);
    settle(2);
    `CHK("buzzer quiet", 1'b0, buzzer)
    `CHK("crit released", 6'h00, crit)
    bus_wr(1, alfrc_pkg::ADDR_CENTRE, 32'h0205);
    xfer_a <= 1'b1;
    settle(4);
    `CHK("remote blocked", 3'h0, remote_out)
    `CHK("local", 3'h2, local_out)
    @(posedge sys_clk_i);
    xfer_b <= 1'b1;
    settle(6);
    `CHK("remote passed", 3'h5, remote_out)
    bus_rd(0, alfrc_pkg::ADDR_LAMP, 32'h0002_0504);
    @(posedge sys_clk_i);
    xfer_b <= 1'b0;
    settle(6);
    bus_rd(0, alfrc_pkg::ADDR_LAMP, 32'h0002_0000);
    bus_wr(1, alfrc_pkg::ADDR_FAN_SET, 32'h05);
    bus_wr(1, alfrc_pkg::ADDR_FAN_SET, 32'h02);
    settle(2);
    `CHK("fan set", 6'h07, fan_off)
    bus_wr(1, alfrc_pkg::ADDR_FAN_CLR, 32'h01);
    settle(2);
    `CHK("fan clear", 6'h06, fan_off)
    bus_rd(0, alfrc_pkg::ADDR_FAN_STATE, 32'h06);
    bus_wr(1, alfrc_pkg::ADDR_INT_CLR, 32'hffff_ffff);
    fan_fail <= 6'h24;
    settle(4);
    bus_rd(0, alfrc_pkg::ADDR_FAN_ALARM, 32'h24);
    bus_rd(1, alfrc_pkg::ADDR_INT_STAT, 32'h2400);
    bus_wr(1, alfrc_pkg::ADDR_INT_EN, 32'h2000);
    settle(2);
    `CHK("irq fan", 1'b1, irq)
    bus_wr(1, alfrc_pkg::ADDR_INT_EN, 32'h0100);
    settle(2);
    `CHK("irq fan masked", 1'b0, irq)
    for (int k = 0; k < 4; k++)
    begin
      bus_wr(1, alfrc_pkg::ADDR_LED, {26'h0, k[1:0], k[1:0], k[1:0]});
      settle(2);
      `CHK("led crit", k[1:0], led_c)
      `CHK("led major", k[1:0], led_j)
      `CHK("led minor", k[1:0], led_n)
    end
    bus_wr(1, alfrc_pkg::ADDR_LED, 32'h35);
    settle(2);
    `CHK("led crit red", alfrc_pkg::LED_RED, led_c)
    `CHK("led minor amber", alfrc_pkg::LED_AMBER, led_n)
    // A write while the clock enable is low must leave the register untouched
    @(posedge sys_clk_i);
    ce <= 1'b0;
    bus_wr(1, alfrc_pkg::ADDR_LED, 32'h0a);
    ce <= 1'b1;
    bus_rd(0, alfrc_pkg::ADDR_LED, 32'h35);
    bus_wr(1, alfrc_pkg::ADDR_GP_RELAY, 32'ha5);
    settle(2);
    `CHK("gp relay", 8'ha5, gp)
    @(posedge sys_clk_i);
    rst_n_i <= 1'b0;
    settle(2);
    @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    settle(1);
    `CHK("gp after reset", 8'ha5, gp)
    bus_rd(0, alfrc_pkg::ADDR_GP_RELAY, 32'ha5);
    bus_rd(0, 6'h3c, 32'h0);
    give_verdict();
  end
endmodule
